/* fpdg_pkg.sv */
// Purpose: Shared constants and types for the flash protection and debug gate
// Assumes: APB slave, 32-bit data, one aligned word per register
// Notes: All offsets and field positions below are local choices
package fpdg_pkg;

  localparam int unsigned FPDG_ADDR_W = 8;
  localparam int unsigned FPDG_ROWS = 32;
  localparam int unsigned FPDG_ROW_W = 5;
  localparam int unsigned FPDG_NUM_BP = 4;
  localparam int unsigned FPDG_NUM_WP = 2;

  // Register byte offsets
  localparam logic [7:0] FPDG_OFS_CTRL = 8'h00;
  localparam logic [7:0] FPDG_OFS_STAT = 8'h04;
  localparam logic [7:0] FPDG_OFS_WPROT = 8'h08;
  localparam logic [7:0] FPDG_OFS_RPROT = 8'h0c;
  localparam logic [7:0] FPDG_OFS_BP0 = 8'h10;
  localparam logic [7:0] FPDG_OFS_WP0 = 8'h20;
  localparam logic [7:0] FPDG_OFS_HIT = 8'h28;

  // Control register fields
  localparam int unsigned FPDG_CTRL_REQ_LSB = 0;
  localparam int unsigned FPDG_CTRL_DBGDIS_BIT = 4;
  localparam int unsigned FPDG_CTRL_SECURE_BIT = 5;

  // Protection state request codes
  localparam logic [2:0] FPDG_REQ_NONE = 3'h0;
  localparam logic [2:0] FPDG_REQ_LOCK = 3'h1;
  localparam logic [2:0] FPDG_REQ_UNLOCK = 3'h2;
  localparam logic [2:0] FPDG_REQ_PERM = 3'h3;

  localparam logic [31:0] FPDG_RST_WORD = 32'h0000_0000;

  typedef enum logic [2:0] {
    FPDG_UNLOCKED = 3'b001,
    FPDG_DEBUG_LOCKED = 3'b010,
    FPDG_PERM_LOCK = 3'b100
  } fpdg_prot_t;

  typedef struct packed {
    logic valid;
    logic write;
    logic erase;
    logic full_erase;
    logic [FPDG_ROW_W-1:0] row;
  } fpdg_flash_req_t;

  typedef struct packed {
    logic valid;
    logic [31:0] addr;
    logic [31:0] data;
    logic write;
  } fpdg_bus_obs_t;

endpackage : fpdg_pkg

/* fpdg_bp_unit.sv */
// Purpose: Address breakpoint and data watchpoint comparators
// Assumes: Observed bus beat is on the system clock
// Notes: Hit flags are registered, one cycle after the beat
`timescale 1ns/1ns
module fpdg_bp_unit #(
  parameter int unsigned NUM_BP = 4,
  parameter int unsigned NUM_WP = 2
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire fpdg_pkg::fpdg_bus_obs_t obs,
  input wire logic [NUM_BP*32-1:0] bp_addr,
  input wire logic [NUM_BP-1:0] bp_en,
  input wire logic [NUM_WP*32-1:0] wp_data,
  input wire logic [NUM_WP-1:0] wp_en,
  output logic [NUM_BP-1:0] bp_hit_r,
  output logic [NUM_WP-1:0] wp_hit_r
);
  import fpdg_pkg::*;

  genvar gi;
  generate
    for (gi = 0; gi < NUM_BP; gi++) begin : g_bp
      always_ff @(posedge clk_sys) begin
        if (rst) begin
          bp_hit_r[gi] <= 1'b0;
        end else begin
          bp_hit_r[gi] <= bp_en[gi] && obs.valid && (obs.addr == bp_addr[gi*32 +: 32]); // [RQ11]
        end
      end
    end
    for (gi = 0; gi < NUM_WP; gi++) begin : g_wp
      always_ff @(posedge clk_sys) begin
        if (rst) begin
          wp_hit_r[gi] <= 1'b0;
        end else begin
          wp_hit_r[gi] <= wp_en[gi] && obs.valid && (obs.data == wp_data[gi*32 +: 32]); // [RQ11]
        end
      end
    end
  endgenerate

endmodule : fpdg_bp_unit

/* fpdg_gate.sv */
// Purpose: Chip-level flash protection state, debug gating and row protection
// Assumes: Firmware reaches registers over APB; debug link requests arrive on this clock
// Notes: Protection state is volatile here; a real part would back it with flash
//
// Overview of operation
// RQ1 - Reset leaves the device unlocked, with no flash protection applied.
// RQ2 - Unlocked may move to debug locked; debug accesses refused there.
// RQ3 - Debug locked returns to unlocked only after a completed full erase.
// RQ4 - Unlocked may move to permanent lock; every debug access blocked.
// RQ5 - Permanent lock refuses external erase and is never left.
// RQ6 - Row protection blocks writes and selectively blocks reads per row.
// RQ7 - Internal system call flash requests always proceed regardless of state.
// RQ8 - Debug enabled at reset; only firmware may disable it.
// RQ9 - Host re-enables debug by erase, unprotect and new firmware.
// RQ10 - Maximum security permanently disables programming, debug and test ports.
// RQ11 - Four address breakpoints and two data watchpoints reachable over debug.
// RQ12 - Undocumented protection state changes are ignored; state holds.
`timescale 1ns/1ns
module fpdg_gate #(
  parameter int unsigned ROWS = fpdg_pkg::FPDG_ROWS
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [fpdg_pkg::FPDG_ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire fpdg_pkg::fpdg_flash_req_t dbg_req,
  input wire fpdg_pkg::fpdg_flash_req_t sys_req,
  input wire logic flash_erase_done,
  input wire fpdg_pkg::fpdg_bus_obs_t obs,
  output logic dbg_grant_r,
  output logic dbg_refuse_r,
  output logic sys_grant_r,
  output logic sys_refuse_r,
  output logic dbg_port_en_r,
  output logic test_port_en_r,
  output logic [2:0] prot_state_r,
  output logic [fpdg_pkg::FPDG_NUM_BP-1:0] bp_hit_r,
  output logic [fpdg_pkg::FPDG_NUM_WP-1:0] wp_hit_r
);
  import fpdg_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // State
  fpdg_prot_t prot_r;
  fpdg_prot_t prot_nxt;
  logic dbg_dis_r;
  logic secure_r;
  logic erased_r;
  logic [ROWS-1:0] wprot_r;
  logic [ROWS-1:0] rprot_r;
  logic [2:0] req_code;
  logic apb_wr;
  logic apb_rd;
  logic addr_ok;
  logic [31:0] rdata;
  logic dbg_blocked;
  logic row_block;
  logic [FPDG_NUM_BP*32-1:0] bp_addr_r;
  logic [FPDG_NUM_BP-1:0] bp_en_r;
  logic [FPDG_NUM_WP*32-1:0] wp_data_r;
  logic [FPDG_NUM_WP-1:0] wp_en_r;

  // Commit only on the completing edge, so one transfer never writes twice
  assign apb_wr = psel && penable && pwrite && pready;
  assign apb_rd = psel && penable && !pwrite;
  assign req_code = (apb_wr && paddr == FPDG_OFS_CTRL) ?
      pwdata[FPDG_CTRL_REQ_LSB +: 3] : FPDG_REQ_NONE;

  ////////////////////////////////////////////////////////////////////////////
  // Protection state transitions
  always_comb begin
    prot_nxt = prot_r;
    case (prot_r)
      FPDG_UNLOCKED: begin
        if (req_code == FPDG_REQ_LOCK) begin
          prot_nxt = FPDG_DEBUG_LOCKED; // [RQ2]
        end else if (req_code == FPDG_REQ_PERM) begin
          prot_nxt = FPDG_PERM_LOCK; // [RQ4]
        end
      end
      FPDG_DEBUG_LOCKED: begin
        if (req_code == FPDG_REQ_UNLOCK && erased_r) begin
          prot_nxt = FPDG_UNLOCKED; // [RQ3]
        end
      end
      FPDG_PERM_LOCK: begin
        prot_nxt = FPDG_PERM_LOCK; // [RQ5]
      end
      default: begin
        prot_nxt = FPDG_PERM_LOCK;
      end
    endcase
  end

  // Any other request leaves prot_nxt at the current state [RQ12]
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      prot_r <= FPDG_UNLOCKED; // [RQ1]
    end else begin
      prot_r <= prot_nxt;
    end
  end

  // Full erase evidence; cleared on leaving debug lock so it must be redone
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      erased_r <= 1'b0;
    end else if (prot_r != FPDG_DEBUG_LOCKED) begin
      erased_r <= 1'b0;
    end else if (flash_erase_done) begin
      erased_r <= 1'b1; // [RQ3]
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Debug disable and maximum security, firmware writable only
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      dbg_dis_r <= 1'b0; // [RQ8]
    end else if (apb_wr && paddr == FPDG_OFS_CTRL) begin
      dbg_dis_r <= pwdata[FPDG_CTRL_DBGDIS_BIT]; // [RQ8]
    end
  end

  // Sticky: only reset clears it, modelling a one-time fuse
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      secure_r <= 1'b0;
    end else if (apb_wr && paddr == FPDG_OFS_CTRL && pwdata[FPDG_CTRL_SECURE_BIT]) begin
      secure_r <= 1'b1; // [RQ10]
    end
  end

  assign dbg_blocked = (prot_r != FPDG_UNLOCKED) || dbg_dis_r || secure_r; // [RQ2] [RQ4] [RQ10]

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      dbg_port_en_r <= 1'b1;
      test_port_en_r <= 1'b1;
    end else begin
      dbg_port_en_r <= !dbg_blocked; // [RQ8]
      test_port_en_r <= !secure_r && prot_r != FPDG_PERM_LOCK; // [RQ10]
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Row protection registers
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      wprot_r <= '0;
      rprot_r <= '0;
    end else if (apb_wr && paddr == FPDG_OFS_WPROT) begin
      wprot_r <= pwdata[ROWS-1:0]; // [RQ6]
    end else if (apb_wr && paddr == FPDG_OFS_RPROT) begin
      rprot_r <= pwdata[ROWS-1:0]; // [RQ6]
    end
  end

  assign row_block = dbg_req.erase ? 1'b0 :
      (dbg_req.write ? wprot_r[dbg_req.row] : rprot_r[dbg_req.row]);

  ////////////////////////////////////////////////////////////////////////////
  // Debug link flash requests
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      dbg_grant_r <= 1'b0;
      dbg_refuse_r <= 1'b0;
    end else if (dbg_req.valid) begin
      if (dbg_blocked || row_block) begin
        dbg_grant_r <= 1'b0; // [RQ2] [RQ4] [RQ5] [RQ6]
        dbg_refuse_r <= 1'b1;
      end else begin
        dbg_grant_r <= 1'b1;
        dbg_refuse_r <= 1'b0;
      end
    end else begin
      dbg_grant_r <= 1'b0;
      dbg_refuse_r <= 1'b0;
    end
  end

  // Internal system call requests bypass chip-level state and row protection
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      sys_grant_r <= 1'b0;
      sys_refuse_r <= 1'b0;
    end else begin
      sys_grant_r <= sys_req.valid; // [RQ7]
      sys_refuse_r <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      prot_state_r <= FPDG_UNLOCKED;
    end else begin
      prot_state_r <= prot_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Breakpoint and watchpoint setup
  genvar gi;
  generate
    for (gi = 0; gi < FPDG_NUM_BP; gi++) begin : g_bpr
      always_ff @(posedge clk_sys) begin
        if (rst) begin
          bp_addr_r[gi*32 +: 32] <= FPDG_RST_WORD;
          bp_en_r[gi] <= 1'b0;
        end else if (apb_wr && paddr == FPDG_OFS_BP0 + 8'(gi * 4)) begin
          bp_addr_r[gi*32 +: 32] <= {pwdata[31:1], 1'b0};
          bp_en_r[gi] <= pwdata[0]; // [RQ11]
        end
      end
    end
    for (gi = 0; gi < FPDG_NUM_WP; gi++) begin : g_wpr
      always_ff @(posedge clk_sys) begin
        if (rst) begin
          wp_data_r[gi*32 +: 32] <= FPDG_RST_WORD;
          wp_en_r[gi] <= 1'b0;
        end else if (apb_wr && paddr == FPDG_OFS_WP0 + 8'(gi * 4)) begin
          wp_data_r[gi*32 +: 32] <= pwdata;
          wp_en_r[gi] <= 1'b1; // [RQ11]
        end
      end
    end
  endgenerate

  fpdg_bp_unit #(
    .NUM_BP(FPDG_NUM_BP),
    .NUM_WP(FPDG_NUM_WP)
  ) u_bp (
    .clk_sys(clk_sys),
    .rst(rst),
    .obs(obs),
    .bp_addr(bp_addr_r),
    .bp_en(bp_en_r & {FPDG_NUM_BP{!dbg_blocked}}),
    .wp_data(wp_data_r),
    .wp_en(wp_en_r & {FPDG_NUM_WP{!dbg_blocked}}),
    .bp_hit_r(bp_hit_r),
    .wp_hit_r(wp_hit_r)
  );

  ////////////////////////////////////////////////////////////////////////////
  // APB read mux and answer; one wait state keeps prdata registered
  always_comb begin
    addr_ok = 1'b1;
    rdata = FPDG_RST_WORD;
    case (paddr)
      FPDG_OFS_CTRL: rdata = {26'h0, secure_r, dbg_dis_r, 4'h0};
      FPDG_OFS_STAT: rdata = {27'h0, erased_r, dbg_blocked, prot_r};
      FPDG_OFS_WPROT: rdata = 32'(wprot_r);
      FPDG_OFS_RPROT: rdata = 32'(rprot_r);
      FPDG_OFS_HIT: rdata = {26'h0, wp_hit_r, bp_hit_r};
      default: begin
        if (paddr >= FPDG_OFS_BP0 && paddr < FPDG_OFS_BP0 + 8'h10 && paddr[1:0] == 2'h0) begin
          rdata = bp_addr_r[paddr[3:2]*32 +: 32] | 32'(bp_en_r[paddr[3:2]]);
        end else if (paddr >= FPDG_OFS_WP0 && paddr < FPDG_OFS_WP0 + 8'h08 &&
                     paddr[1:0] == 2'h0) begin
          rdata = wp_data_r[paddr[2]*32 +: 32];
        end else begin
          addr_ok = 1'b0;
        end
      end
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= FPDG_RST_WORD;
    end else begin
      pready <= psel && penable && !pready;
      pslverr <= psel && penable && !pready && !addr_ok;
      prdata <= (apb_rd && !pready && addr_ok) ? rdata : FPDG_RST_WORD;
    end
  end

endmodule : fpdg_gate

/* fpdg_checker.sv */
// Purpose: Port-level checks on the protection gate
// Assumes: One clock, synchronous active-high reset
// Notes: Bound to every fpdg_gate instance
`timescale 1ns/1ns
module fpdg_checker (
  input wire logic clk_sys,
  input wire logic rst,
  input wire fpdg_pkg::fpdg_flash_req_t dbg_req,
  input wire fpdg_pkg::fpdg_flash_req_t sys_req,
  input wire logic flash_erase_done,
  input wire fpdg_pkg::fpdg_bus_obs_t obs,
  input wire logic dbg_grant_r,
  input wire logic dbg_refuse_r,
  input wire logic sys_grant_r,
  input wire logic sys_refuse_r,
  input wire logic dbg_port_en_r,
  input wire logic test_port_en_r,
  input wire logic [2:0] prot_state_r,
  input wire logic [fpdg_pkg::FPDG_NUM_BP-1:0] bp_hit_r
);
  import fpdg_pkg::*;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  logic erase_seen_r;
  ////////////////////////////////////////
  // Erase latch kept here so the unlock check needs no long history
  always_ff @(posedge clk_sys) begin
    if (rst || prot_state_r != 3'b010) erase_seen_r <= 1'b0;
    else if (flash_erase_done) erase_seen_r <= 1'b1;
  end
  reset_open_a: assert property (
    $fell(rst) |-> prot_state_r == 3'b001 && dbg_port_en_r && test_port_en_r)
    else $error("state or ports wrong after reset");
  locked_refuse_a: assert property (
    dbg_req.valid && prot_state_r != 3'b001 |=> dbg_refuse_r && !dbg_grant_r)
    else $error("debug access not refused while locked");
  grant_cause_a: assert property (
    dbg_grant_r |-> $past(dbg_req.valid) && $past(dbg_port_en_r) && $past(prot_state_r) == 3'b001)
    else $error("debug grant without cause");
  perm_hold_a: assert property (
    prot_state_r == 3'b100 |=> prot_state_r == 3'b100)
    else $error("permanent lock left");
  lock_entry_a: assert property (
    $changed(prot_state_r) && prot_state_r != 3'b001 |-> $past(prot_state_r) == 3'b001)
    else $error("lock entered from wrong state");
  unlock_erase_a: assert property (
    $changed(prot_state_r) && prot_state_r == 3'b001 |-> $past(erase_seen_r))
    else $error("unlock without full erase");
  sys_always_a: assert property (
    sys_req.valid |=> sys_grant_r && !sys_refuse_r)
    else $error("system call not granted");
  secure_stick_a: assert property (
    !test_port_en_r |=> !test_port_en_r && !dbg_port_en_r)
    else $error("secure lockout not kept");
  bp_cause_a: assert property (
    |bp_hit_r |-> $past(obs.valid))
    else $error("breakpoint hit without beat");
  cover property (prot_state_r == 3'b100);
  cover property ($fell(dbg_port_en_r));
  cover property (dbg_refuse_r);
endmodule : fpdg_checker

bind fpdg_gate fpdg_checker u_fpdg_checker (
  .clk_sys, .rst, .dbg_req, .sys_req, .flash_erase_done, .obs, .dbg_grant_r,
  .dbg_refuse_r, .sys_grant_r, .sys_refuse_r, .dbg_port_en_r, .test_port_en_r,
  .prot_state_r, .bp_hit_r
);

/* fpdg_host_model.sv */
// Purpose: Debug host issuing flash requests over the debug link
// Assumes: Requests launched right after a rising edge
// Notes: The answer is taken in the cycle after the request
`timescale 1ns/1ns
module fpdg_host_model (
  input wire logic clk_sys,
  input wire logic dbg_grant_r,
  input wire logic dbg_refuse_r,
  output fpdg_pkg::fpdg_flash_req_t dbg_req
);
  import fpdg_pkg::*;
  initial dbg_req = '0;
  ////////////////////////////////////////
  // Valid is a single-cycle pulse, so a held request is never seen twice
  task automatic access(input logic wr, input logic er, input logic [4:0] row,
                        output logic [1:0] ans);
    @(posedge clk_sys);
    dbg_req <= '{1'b1, wr, er, er, row};
    @(posedge clk_sys);
    dbg_req <= '0;
    #1;
    ans = {dbg_grant_r, dbg_refuse_r};
  endtask : access
endmodule : fpdg_host_model

/* tb_top.sv */
// Purpose: Self-checking bench for the protection gate
// Assumes: APB master and debug host tasks
// Notes: Protection state is volatile, so one run covers every lock
`timescale 1ns/1ns
module tb_top;
  import fpdg_pkg::*;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, rd;
  logic pready, pslverr, dbg_grant_r, dbg_refuse_r, sys_grant_r, sys_refuse_r;
  logic dbg_port_en_r, test_port_en_r;
  logic [2:0] prot_state_r;
  logic [3:0] bp_hit_r;
  logic [1:0] wp_hit_r, ans;
  fpdg_flash_req_t dbg_req;
  fpdg_flash_req_t sys_req = '0;
  logic flash_erase_done = 1'b0;
  fpdg_bus_obs_t obs = '0;
  int fails = 0;
  int compares = 0;
  always #10 clk_sys = ~clk_sys;
  fpdg_gate u_fpdg_gate (.clk_sys, .rst, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .dbg_req, .sys_req, .flash_erase_done, .obs,
    .dbg_grant_r, .dbg_refuse_r, .sys_grant_r, .sys_refuse_r, .dbg_port_en_r,
    .test_port_en_r, .prot_state_r, .bp_hit_r, .wp_hit_r);
  fpdg_host_model u_fpdg_host_model (.clk_sys, .dbg_grant_r, .dbg_refuse_r, .dbg_req);
  ////////////////////////////////////////
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      fails++;
      $display("wrong value at %0t: got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     input logic err);
    @(posedge clk_sys);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    @(posedge clk_sys);
    while (pready !== 1'b1) begin
      @(posedge clk_sys);
    end
    rd = prdata;
    chk({30'h0, pready, pslverr}, {30'h0, 1'b1, err});
    psel <= 1'b0;
    penable <= 1'b0;
    #1;
  endtask : apb
  task automatic ctl(input logic [31:0] d);
    apb(1'b1, FPDG_OFS_CTRL, d, 1'b0);
  endtask : ctl
  task automatic st(input logic [2:0] e);
    chk({29'h0, prot_state_r}, {29'h0, e});
  endtask : st
  task automatic dchk(input logic wr, input logic er, input logic [4:0] row,
                      input logic [1:0] e);
    u_fpdg_host_model.access(wr, er, row, ans);
    chk({30'h0, ans}, {30'h0, e});
  endtask : dchk
  task automatic sreq(input logic wr, input logic [4:0] row);
    @(posedge clk_sys);
    sys_req <= '{1'b1, wr, 1'b0, 1'b0, row};
    @(posedge clk_sys);
    sys_req <= '0;
    #1;
    chk({30'h0, sys_grant_r, sys_refuse_r}, 32'h2);
  endtask : sreq
  task automatic erase_pulse;
    @(posedge clk_sys);
    flash_erase_done <= 1'b1;
    @(posedge clk_sys);
    flash_erase_done <= 1'b0;
  endtask : erase_pulse
  task automatic beat(input logic [31:0] a, input logic [31:0] d, input logic w,
                      input logic [5:0] e);
    @(posedge clk_sys);
    obs <= '{1'b1, a, d, w};
    @(posedge clk_sys);
    obs <= '0;
    #1;
    chk({26'h0, bp_hit_r, wp_hit_r}, {26'h0, e});
  endtask : beat
  task automatic tally_and_finish;
    if (fails == 0 && compares > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : tally_and_finish
  ////////////////////////////////////////
  initial begin
    repeat (8) @(posedge clk_sys);
    rst <= 1'b0;
    @(posedge clk_sys);
    #1;
    st(3'b001);
    chk({30'h0, dbg_port_en_r, test_port_en_r}, 32'h3);
    dchk(1'b1, 1'b0, 5'd3, 2'b10);
    apb(1'b1, FPDG_OFS_WPROT, 32'h0000_0008, 1'b0);
    apb(1'b1, FPDG_OFS_RPROT, 32'h0000_0020, 1'b0);
    dchk(1'b1, 1'b0, 5'd3, 2'b01);
    dchk(1'b0, 1'b0, 5'd3, 2'b10);
    dchk(1'b0, 1'b0, 5'd5, 2'b01);
    dchk(1'b0, 1'b1, 5'd3, 2'b10);
    sreq(1'b1, 5'd3);
    ctl(32'h2);
    st(3'b001);
    ctl(32'h1);
    st(3'b010);
    dchk(1'b0, 1'b0, 5'd0, 2'b01);
    sreq(1'b0, 5'd5);
    apb(1'b0, FPDG_OFS_STAT, 32'h0, 1'b0);
    chk({29'h0, rd[2:0]}, 32'h2);
    ctl(32'h2);
    st(3'b010);
    ctl(32'h3);
    st(3'b010);
    erase_pulse();
    ctl(32'h2);
    st(3'b001);
    ctl(32'h10);
    dchk(1'b0, 1'b0, 5'd0, 2'b01);
    erase_pulse();
    apb(1'b1, FPDG_OFS_WPROT, 32'h0, 1'b0);
    apb(1'b1, FPDG_OFS_RPROT, 32'h0, 1'b0);
    ctl(32'h0);
    dchk(1'b0, 1'b0, 5'd0, 2'b10);
    apb(1'b0, 8'h80, 32'h0, 1'b1);
    chk(rd, 32'h0);
    for (int i = 0; i < 4; i++) begin
      apb(1'b1, FPDG_OFS_BP0 + 8'(4 * i), 32'h101 + 32'(16 * i), 1'b0);
      beat(32'h100 + 32'(16 * i), 32'h0, 1'b0, 6'h4 << i);
    end
    for (int j = 0; j < 2; j++) begin
      apb(1'b1, FPDG_OFS_WP0 + 8'(4 * j), 32'ha500 + 32'(j), 1'b0);
      beat(32'hff0, 32'ha500 + 32'(j), 1'b1, 6'h1 << j);
    end
    ctl(32'h3);
    st(3'b100);
    dchk(1'b0, 1'b1, 5'd0, 2'b01);
    erase_pulse();
    ctl(32'h2);
    st(3'b100);
    ctl(32'h20);
    chk({30'h0, dbg_port_en_r, test_port_en_r}, 32'h0);
    ctl(32'h0);
    chk({30'h0, dbg_port_en_r, test_port_en_r}, 32'h0);
    tally_and_finish();
  end
  initial begin
    #100000;
    fails++;
    tally_and_finish();
  end
endmodule : tb_top
